// ===== rssa_defines.svh
// Constants for the rotate, shift and subtract datapath
`ifndef RSSA_DEFINES_SVH
`define RSSA_DEFINES_SVH
`define RSSA_OP_RR 8'hE0
`define RSSA_OP_RR_IND 8'hE1
`define RSSA_OP_RRC 8'hC0
`define RSSA_OP_RRC_IND 8'hC1
`define RSSA_OP_SRA 8'hD0
`define RSSA_OP_SRA_IND 8'hD1
`define RSSA_OP_SCF 8'hDF
`define RSSA_OP_SBC_RR 8'h32
`define RSSA_OP_SBC_RIR 8'h33
`define RSSA_OP_SBC_REG 8'h34
`define RSSA_OP_SBC_IND 8'h35
`define RSSA_OP_SBC_IMM 8'h36
`define RSSA_CYC_SHORT 4'h4
`define RSSA_CYC_LONG 4'h6
`define RSSA_LEN_ONE 2'h1
`define RSSA_LEN_TWO 2'h2
`define RSSA_LEN_THREE 2'h3
`define RSSA_FLAGS_RST 4'h0
`endif

// ===== rssa_pkg.sv
// Types for the rotate, shift and subtract datapath
package rssa_pkg;
   typedef enum logic [2:0] {
      rotate_right_op, rotate_right_through_carry_op, subtract_with_borrow_op,
      force_carry_op, arith_shift_right_op, illegal_op
   } rssa_op_type;
   typedef struct packed {
      logic c;
      logic z;
      logic s;
      logic v;
   } rssa_flags_type;
   typedef struct packed {
      rssa_op_type op;
      logic indirect_register_mode;
      logic indirect_working_register_mode;
      logic immediate_mode;
      logic src_is_reg;
      logic [1:0] length;
      logic [3:0] cycles;
   } rssa_dec_type;
   typedef struct packed {
      logic [7:0] result;
      rssa_flags_type flags;
      logic write_dst;
   } rssa_res_type;
endpackage

// ===== rssa_alu.sv
// Combinational result and flag logic
`timescale 1ns/100ps
`default_nettype none
module rssa_alu
   import rssa_pkg::*;
(
   input wire rssa_op_type op,
   input wire logic [7:0] dst,
   input wire logic [7:0] src,
   input wire rssa_flags_type flags_in,
   output rssa_res_type res
);
   logic [8:0] diff;
   always_comb begin
      diff = {1'b0, dst} - {1'b0, src} - {8'h00, flags_in.c};
      res.result = dst;
      res.flags = flags_in;
      res.write_dst = 1'b0;
      case (op)
         rotate_right_op: begin
            res.result = {dst[0], dst[7:1]};
            res.flags.c = dst[0];
            res.write_dst = 1'b1;
         end
         rotate_right_through_carry_op: begin
            res.result = {flags_in.c, dst[7:1]};
            res.flags.c = dst[0];
            res.write_dst = 1'b1;
         end
         arith_shift_right_op: begin
            res.result = {dst[7], dst[7:1]};
            res.flags.c = dst[0];
            res.write_dst = 1'b1;
         end
         subtract_with_borrow_op: begin
            res.result = diff[7:0];
            res.flags.c = diff[8];
            res.write_dst = 1'b1;
         end
         force_carry_op: begin
            res.flags.c = 1'b1;
         end
         default: begin
            res.write_dst = 1'b0;
         end
      endcase
      if (res.write_dst) begin
         res.flags.z = (res.result == 8'h00);
         res.flags.s = res.result[7];
      end
      case (op)
         rotate_right_op, rotate_right_through_carry_op: res.flags.v = res.result[7] ^ dst[7];
         arith_shift_right_op: res.flags.v = 1'b0;
         subtract_with_borrow_op: res.flags.v = (dst[7] ^ src[7]) & (res.result[7] == src[7]);
         default: res.flags.v = flags_in.v;
      endcase
   end
endmodule
`default_nettype wire

// ===== rssa_core.sv
// Sequenced executor: decode, operand fetch, write back
`timescale 1ns/100ps
`default_nettype none
`include "rssa_defines.svh"
module rssa_core
   import rssa_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic start,
   input wire logic [7:0] opcode,
   input wire logic [7:0] byte2,
   input wire logic [7:0] byte3,
   output logic rf_rd_en_ff,
   output logic [7:0] rf_rd_addr_ff,
   input wire logic [7:0] rf_rd_data,
   output logic rf_wr_en_ff,
   output logic [7:0] rf_wr_addr_ff,
   output logic [7:0] rf_wr_data_ff,
   output logic [3:0] flags_ff,
   output logic busy_ff,
   output logic done_ff,
   output logic illegal_ff,
   output logic [1:0] length_ff
);
   ////////////////////////////////////////////////////////////////////////////
   typedef enum logic [2:0] {
      st_idle, st_ptr, st_dst, st_src_ptr, st_src, st_exec, st_wait
   } rssa_state_type;
   rssa_state_type state_ff;
   rssa_dec_type dec, dec_ff;
   logic [7:0] dst_addr_ff, src_addr_ff, dst_val_ff, src_val_ff;
   logic [3:0] cnt_ff;
   rssa_res_type res;
   rssa_flags_type cur_flags;

   assign cur_flags = flags_ff;

   // Decode table, lengths and cycle counts per opcode
   always_comb begin
      dec = '0;
      dec.op = illegal_op;
      dec.length = `RSSA_LEN_TWO;
      dec.cycles = `RSSA_CYC_SHORT;
      case (opcode)
         `RSSA_OP_RR: dec.op = rotate_right_op;
         `RSSA_OP_RR_IND: begin
            dec.op = rotate_right_op;
            dec.indirect_register_mode = 1'b1;
         end
         `RSSA_OP_RRC: dec.op = rotate_right_through_carry_op;
         `RSSA_OP_RRC_IND: begin
            dec.op = rotate_right_through_carry_op;
            dec.indirect_register_mode = 1'b1;
         end
         `RSSA_OP_SRA: dec.op = arith_shift_right_op;
         `RSSA_OP_SRA_IND: begin
            dec.op = arith_shift_right_op;
            dec.indirect_register_mode = 1'b1;
         end
         `RSSA_OP_SCF: begin
            dec.op = force_carry_op;
            dec.length = `RSSA_LEN_ONE;
         end
         `RSSA_OP_SBC_RR: begin
            dec.op = subtract_with_borrow_op;
            dec.src_is_reg = 1'b1;
         end
         `RSSA_OP_SBC_RIR: begin
            dec.op = subtract_with_borrow_op;
            dec.indirect_working_register_mode = 1'b1;
            dec.cycles = `RSSA_CYC_LONG;
         end
         `RSSA_OP_SBC_REG: begin
            dec.op = subtract_with_borrow_op;
            dec.src_is_reg = 1'b1;
            dec.length = `RSSA_LEN_THREE;
            dec.cycles = `RSSA_CYC_LONG;
         end
         `RSSA_OP_SBC_IND: begin
            dec.op = subtract_with_borrow_op;
            dec.indirect_register_mode = 1'b1;
            dec.length = `RSSA_LEN_THREE;
            dec.cycles = `RSSA_CYC_LONG;
         end
         `RSSA_OP_SBC_IMM: begin
            dec.op = subtract_with_borrow_op;
            dec.immediate_mode = 1'b1;
            dec.length = `RSSA_LEN_THREE;
            dec.cycles = `RSSA_CYC_LONG;
         end
         default: dec.op = illegal_op;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   rssa_alu u_alu (
      .op(dec_ff.op),
      .dst(dst_val_ff),
      .src(src_val_ff),
      .flags_in(cur_flags),
      .res(res)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer; total cycles padded to the documented count
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_ff <= st_idle;
         dec_ff <= '0;
         dst_addr_ff <= 8'h00;
         src_addr_ff <= 8'h00;
         dst_val_ff <= 8'h00;
         src_val_ff <= 8'h00;
         cnt_ff <= 4'h0;
         rf_rd_en_ff <= 1'b0;
         rf_rd_addr_ff <= 8'h00;
         busy_ff <= 1'b0;
         illegal_ff <= 1'b0;
         length_ff <= 2'h0;
      end else begin
         rf_rd_en_ff <= 1'b0;
         cnt_ff <= cnt_ff + 4'h1;
         case (state_ff)
            st_idle: begin
               cnt_ff <= 4'h1;
               if (start) begin
                  dec_ff <= dec;
                  illegal_ff <= (dec.op == illegal_op);
                  length_ff <= dec.length;
                  busy_ff <= (dec.op != illegal_op);
                  // For 34/35 the source byte precedes the destination
                  dst_addr_ff <= (dec.length == `RSSA_LEN_THREE && !dec.immediate_mode) ? byte3 : byte2;
                  src_addr_ff <= (dec.length == `RSSA_LEN_THREE && !dec.immediate_mode) ? byte2 : byte3;
                  src_val_ff <= byte3;
                  if (dec.op == force_carry_op) begin
                     state_ff <= st_exec;
                  end else if (dec.op != illegal_op) begin
                     rf_rd_en_ff <= 1'b1;
                     rf_rd_addr_ff <= (dec.length == `RSSA_LEN_THREE && !dec.immediate_mode) ? byte3 : byte2;
                     state_ff <= (dec.indirect_register_mode && dec.op != subtract_with_borrow_op) ? st_ptr : st_dst;
                  end
               end
            end
            st_ptr: begin
               // Pointer register is only read, never written back
               dst_addr_ff <= rf_rd_data;
               rf_rd_en_ff <= 1'b1;
               rf_rd_addr_ff <= rf_rd_data;
               state_ff <= st_dst;
            end
            st_dst: begin
               dst_val_ff <= rf_rd_data;
               if (dec_ff.op == subtract_with_borrow_op && !dec_ff.immediate_mode) begin
                  rf_rd_en_ff <= 1'b1;
                  rf_rd_addr_ff <= src_addr_ff;
                  state_ff <= dec_ff.src_is_reg ? st_src : st_src_ptr;
               end else begin
                  // Operands ready: straight to wait; indirect forms finish in the same cycle count
                  state_ff <= st_wait;
               end
            end
            st_src_ptr: begin
               rf_rd_en_ff <= 1'b1;
               rf_rd_addr_ff <= rf_rd_data;
               state_ff <= st_src;
            end
            st_src: begin
               src_val_ff <= rf_rd_data;
               state_ff <= st_wait;
            end
            st_exec: begin
               state_ff <= st_wait;
            end
            st_wait: begin
               if (cnt_ff >= dec_ff.cycles - 4'h1) begin
                  state_ff <= st_idle;
                  busy_ff <= 1'b0;
               end
            end
            default: state_ff <= st_idle;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Commit: result write and flags in the same final edge
   logic commit;
   assign commit = (state_ff == st_wait) && (cnt_ff >= dec_ff.cycles - 4'h1);

   // ALU output is steady through wait, operands and flags do not move until commit
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         flags_ff <= `RSSA_FLAGS_RST;
         rf_wr_en_ff <= 1'b0;
         rf_wr_addr_ff <= 8'h00;
         rf_wr_data_ff <= 8'h00;
         done_ff <= 1'b0;
      end else begin
         rf_wr_en_ff <= commit && res.write_dst;
         rf_wr_addr_ff <= dst_addr_ff;
         rf_wr_data_ff <= res.result;
         done_ff <= commit;
         if (commit) begin
            flags_ff <= res.flags;
         end
      end
   end
endmodule
`default_nettype wire

// ===== rssa_core_properties.sv
// Checker for the rotate, shift and subtract executor
`timescale 1ns/100ps
`default_nettype none
module rssa_core_properties
   import rssa_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic start,
   input wire logic [7:0] opcode,
   input wire logic rf_wr_en_ff,
   input wire logic [7:0] rf_wr_data_ff,
   input wire logic [3:0] flags_ff,
   input wire logic busy_ff,
   input wire logic done_ff
);
   logic [7:0] op_ff;
   wire logic take = start && !busy_ff;
   default clocking @(posedge clock);
   endclocking
   default disable iff (reset);
   ////////////////////////////////////////////////////////////
   // Opcode of the instruction in flight, for result checks
   always_ff @(posedge clock or posedge reset) begin
      if (reset)
         op_ff <= 8'h00;
      else if (take)
         op_ff <= opcode;
   end
   ////////////////////////////////////////////////////////////
   AST_SHORT: assert property (take && opcode inside {8'hE0, 8'hE1, 8'hC0, 8'hC1, 8'hD0, 8'hD1, 8'hDF, 8'h32}
      |-> ##1 !done_ff [*3] ##1 done_ff) else $error("short op completion off");
   AST_LONG: assert property (take && opcode inside {[8'h33:8'h36]}
      |-> ##1 !done_ff [*5] ##1 done_ff) else $error("long op completion off");
   AST_FORCE_C: assert property (take && opcode == 8'hDF
      |-> ##4 !rf_wr_en_ff && flags_ff[3] && (flags_ff & 4'h7) == ($past(flags_ff, 4) & 4'h7))
      else $error("force carry wrong");
   AST_WR_DONE: assert property (rf_wr_en_ff |-> done_ff) else $error("write without done");
   AST_FLAGS_HOLD: assert property (!done_ff |-> $stable(flags_ff)) else $error("flags moved early");
   AST_ROT_FLAGS: assert property (done_ff && op_ff inside {8'hE0, 8'hE1, 8'hC0, 8'hC1}
      |-> flags_ff[1] == rf_wr_data_ff[7] && flags_ff[2] == (rf_wr_data_ff == 8'h00)) else $error("rotate flags");
   AST_RR_WRAP: assert property (done_ff && op_ff inside {8'hE0, 8'hE1}
      |-> rf_wr_data_ff[7] == flags_ff[3]) else $error("rotate wrap");
   AST_SRA: assert property (done_ff && op_ff inside {8'hD0, 8'hD1}
      |-> rf_wr_data_ff[7] == rf_wr_data_ff[6] && !flags_ff[0]) else $error("shift sign or overflow");
   AST_SBC_FLAGS: assert property (done_ff && op_ff inside {[8'h32:8'h36]}
      |-> flags_ff[1] == rf_wr_data_ff[7] && flags_ff[2] == (rf_wr_data_ff == 8'h00)) else $error("subtract flags");
   cover property (done_ff && op_ff == 8'h36);
   cover property (done_ff && op_ff == 8'hE1);
   cover property (take && opcode == 8'hDF);
endmodule
`default_nettype wire

// ===== rssa_rf_model.sv
// Register file model facing the executor
`timescale 1ns/100ps
`default_nettype none
module rssa_rf_model (
   input wire logic clock,
   input wire logic rd_en,
   input wire logic [7:0] rd_addr,
   output logic [7:0] rd_data,
   input wire logic wr_en,
   input wire logic [7:0] wr_addr,
   input wire logic [7:0] wr_data
);
   logic [7:0] mem [256];
   // Unread cycles show inverted data so a stale sample is caught
   always_comb begin
      rd_data = rd_en ? mem[rd_addr] : ~mem[rd_addr];
   end
   // Plain always: the bench preloads the array too
   always @(posedge clock) begin
      if (wr_en)
         mem[wr_addr] <= wr_data;
   end
endmodule
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the rotate, shift and subtract executor
`timescale 1ns/100ps
`default_nettype none
module testbench;
   logic clock, reset, start, rf_rd_en_ff, rf_wr_en_ff, busy_ff, done_ff, illegal_ff;
   logic [7:0] opcode, byte2, byte3, rf_rd_addr_ff, rf_rd_data, rf_wr_addr_ff, rf_wr_data_ff;
   logic [3:0] flags_ff;
   logic [1:0] length_ff;
   int num_errors = 0;
   int n_tests = 0;
   logic [7:0] init [28] = '{8'h00, 8'h02, 8'h17, 8'h31, 8'h55, 8'h06, 8'h00, 8'h08, 8'h01, 8'h9A,
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10, 8'h03, 8'h20, 8'h15, 8'h0A, 8'h00, 8'h01,
      8'h19, 8'hFF, 8'h00, 8'h20};
   rssa_core u_rssa_core (.clock, .reset, .start, .opcode, .byte2, .byte3, .rf_rd_en_ff, .rf_rd_addr_ff,
      .rf_rd_data, .rf_wr_en_ff, .rf_wr_addr_ff, .rf_wr_data_ff, .flags_ff, .busy_ff, .done_ff,
      .illegal_ff, .length_ff);
   rssa_rf_model u_rssa_rf_model (.clock, .rd_en(rf_rd_en_ff), .rd_addr(rf_rd_addr_ff),
      .rd_data(rf_rd_data), .wr_en(rf_wr_en_ff), .wr_addr(rf_wr_addr_ff), .wr_data(rf_wr_data_ff));
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   ////////////////////////////////////////////////////////////
   task automatic print_verdict;
      $display("errors %0d tests %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [16:0] got, input logic [16:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One instruction; result looked at in the single done cycle
   task automatic ex(input logic [7:0] op, b2, b3, input int n, input logic [7:0] ea, ed, input logic [3:0] ef);
      @(posedge clock);
      start <= 1'b1;
      opcode <= op;
      byte2 <= b2;
      byte3 <= b3;
      @(posedge clock);
      start <= 1'b0;
      // Done stands only between edges n-1 and n after the taking edge
      repeat (n - 1) @(posedge clock);
      #1;
      chk({done_ff, flags_ff}, {1'b1, ef});
      if (op == 8'hDF)
         chk(rf_wr_en_ff, 1'b0);
      else
         chk({rf_wr_en_ff, rf_wr_addr_ff, rf_wr_data_ff}, {1'b1, ea, ed});
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_rotate;
      ex(8'hE0, 8'h00, 8'h00, 4, 8'h00, 8'h00, 4'h4);
      ex(8'hE0, 8'h03, 8'h00, 4, 8'h03, 8'h98, 4'hB);
      ex(8'hE1, 8'h01, 8'h00, 4, 8'h02, 8'h8B, 4'hB);
      ex(8'hC0, 8'h04, 8'h00, 4, 8'h04, 8'hAA, 4'hB);
      ex(8'hC1, 8'h05, 8'h00, 4, 8'h06, 8'h80, 4'h3);
      chk({u_rssa_rf_model.mem[8'h01], u_rssa_rf_model.mem[8'h05]}, 16'h0206);
      chk(length_ff, 2'h2);
   endtask
   task automatic t_shift;
      ex(8'hD1, 8'h07, 8'h00, 4, 8'h08, 8'h00, 4'hC);
      ex(8'hD0, 8'h09, 8'h00, 4, 8'h09, 8'hCD, 4'h2);
      ex(8'hDF, 8'h00, 8'h00, 4, 8'h00, 8'h00, 4'hA);
      chk(length_ff, 2'h1);
   endtask
   task automatic t_sub;
      ex(8'h32, 8'h11, 8'h12, 4, 8'h11, 8'h0C, 4'h0);
      ex(8'h33, 8'h13, 8'h14, 6, 8'h13, 8'h16, 4'h0);
      ex(8'h34, 8'h17, 8'h16, 6, 8'h16, 8'hFF, 4'hA);
      ex(8'h35, 8'h18, 8'h1A, 6, 8'h1A, 8'h00, 4'hC);
      ex(8'h36, 8'h1B, 8'h8A, 6, 8'h1B, 8'h95, 4'hB);
      chk({u_rssa_rf_model.mem[8'h12], u_rssa_rf_model.mem[8'h14]}, 16'h0315);
      chk(length_ff, 2'h3);
   endtask
   task automatic t_bad;
      @(posedge clock);
      start <= 1'b1;
      opcode <= 8'hFF;
      @(posedge clock);
      start <= 1'b0;
      repeat (2) @(posedge clock);
      #1;
      chk({illegal_ff, busy_ff, rf_wr_en_ff, flags_ff}, {3'b100, 4'hB});
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      #50000;
      num_errors++;
      print_verdict();
   end
   initial begin
      reset = 1'b1;
      start = 1'b0;
      opcode = 8'h00;
      byte2 = 8'h00;
      byte3 = 8'h00;
      foreach (init[i])
         u_rssa_rf_model.mem[i] = init[i];
      repeat (8) @(posedge clock);
      reset <= 1'b0;
      t_rotate();
      t_shift();
      t_sub();
      t_bad();
      print_verdict();
   end
endmodule
bind rssa_core rssa_core_properties u_rssa_core_properties (.clock, .reset, .start, .opcode, .rf_wr_en_ff,
   .rf_wr_data_ff, .flags_ff, .busy_ff, .done_ff);
`default_nettype wire
